// >>> common/dbc_consts.svh
// timing counts and field positions for the bank command state logic
// Contract
// [RQ1] sample command each edge, use prior bank state; the device samples on the rising clock edge only
// [RQ2] decode commands from cs, ras, cas, we
// [RQ3] auto-precharge burst accepts only deselect or nop
// [RQ4] bank-local illegal commands may target other banks
// [RQ5] precharging returns idle after tRP; pre allowed
// [RQ6] activating reaches row active after tRCD
// [RQ7] write recovery: bank active after tWR; write restarts
// [RQ8] write recovery with auto-precharge precharges after tWR
// [RQ9] refresh: only deselect/nop, idle after tRC
// [RQ10] mode register set: only deselect/nop, idle after tMRD
// [RQ11] refresh and mode set need all banks idle
// [RQ12] burst interrupt only with burst length 8
// [RQ13] interrupt only same direction on 4-beat boundary
`ifndef DBC_CONSTS_SVH
`define DBC_CONSTS_SVH
`define DBC_CLK_PS 4000
`define DBC_TRP_PS 15000
`define DBC_TRCD_PS 15000
`define DBC_TWR_PS 15000
`define DBC_TRC_PS 60000
`define DBC_TMRD_CK 2
`define DBC_CYC(ps) (((ps) + `DBC_CLK_PS - 1) / `DBC_CLK_PS)
`define DBC_BL_SHORT 4
`define DBC_BL_LONG 8
`define DBC_BOUNDARY 4
`define DBC_A10_BIT 10
`endif

// >>> common/dbc_if.sv
// command pins between controller and memory device
`timescale 1ns/100ps
`default_nettype none
interface dbc_if #(parameter int BANKS = 4, parameter int AW = 14);
	logic csB;
	logic rasB;
	logic casB;
	logic weB;
	logic [$clog2(BANKS)-1:0] ba;
	logic [AW-1:0] addr;
	modport ctrl (output csB, rasB, casB, weB, ba, addr);
	modport dev (input csB, rasB, casB, weB, ba, addr);
endinterface
`default_nettype wire

// >>> common/dbc_pkg.sv
// command and bank state types for the bank command state logic
package dbc_pkg;
	typedef enum logic [2:0] {
		DBC_DSL, DBC_NOP, DBC_READ, DBC_WRIT, DBC_ACT, DBC_PRE, DBC_AREF, DBC_MRS
	} dbc_cmd_t;
	typedef enum logic [3:0] {
		DBC_IDLE, DBC_ACTIVATING, DBC_ACTIVE, DBC_READING, DBC_WRITING, DBC_READ_AP, DBC_WRITE_AP,
		DBC_PRECHARGING, DBC_WREC, DBC_WREC_AP, DBC_REFRESHING, DBC_MODE_ACC
	} dbc_bank_t;
	function automatic dbc_cmd_t dbc_decode(input logic csB, input logic rasB, input logic casB, input logic weB);
		dbc_cmd_t c;
		c = DBC_DSL;
		if (!csB) begin
			case ({rasB, casB, weB})
				3'h7: c = DBC_NOP;
				3'h5: c = DBC_READ;
				3'h4: c = DBC_WRIT;
				3'h3: c = DBC_ACT;
				3'h2: c = DBC_PRE;
				3'h1: c = DBC_AREF;
				default: c = DBC_MRS;
			endcase
		end
		return c;
	endfunction
endpackage

// >>> tb/dbc_props.sv
// bank command state assertions on the command pins and device outputs
`timescale 1ns/100ps
`default_nettype none
module dbc_props #(parameter int BANKS = 4) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic csB,
	input wire logic rasB,
	input wire logic casB,
	input wire logic weB,
	input wire logic [$clog2(BANKS)-1:0] ba,
	input wire logic [4*BANKS-1:0] bankState,
	input wire logic illegalCmd
);
	import dbc_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire logic nop = csB || (rasB && casB && weB);
	wire logic b0 = (ba == 0) && !nop;
	wire logic wr1 = (ba == 1) && !nop && rasB && !casB && !weB;
	wire logic [3:0] s0 = bankState[3:0];
	wire logic [3:0] s1 = bankState[7:4];
	sequence actHold;
		s0 == DBC_ACTIVATING [*3];
	endsequence
	ap_burst_a: assert property ((s0 == DBC_READ_AP || s0 == DBC_WRITE_AP) && b0 |=> illegalCmd)
		else $error("auto-precharge burst took a command");
	pre_block_a: assert property (s0 == DBC_PRECHARGING && b0 && (rasB || (casB && weB)) |=> illegalCmd)
		else $error("precharging bank took a command");
	act_block_a: assert property (s0 == DBC_ACTIVATING && b0 |=> illegalCmd)
		else $error("activating bank took a command");
	act_time_a: assert property ($rose(s0 == DBC_ACTIVATING) |-> actHold ##[1:2] s0 == DBC_ACTIVE)
		else $error("row activation time wrong");
	wrec_write_a: assert property (s1 == DBC_WREC && wr1 |=> s1 == DBC_WRITING && !illegalCmd)
		else $error("write in recovery not restarted");
	wrec_ap_a: assert property (s0 == DBC_WREC_AP && b0 |=> illegalCmd)
		else $error("recovery with precharge took a command");
	refresh_only_a: assert property (s0 == DBC_REFRESHING && !nop |=> illegalCmd)
		else $error("refresh took a command");
	mode_only_a: assert property (s0 == DBC_MODE_ACC && !nop |=> illegalCmd)
		else $error("mode access took a command");
endmodule
`default_nettype wire

// >>> tb/ddr2_bank_command_state_rules_test.sv
// end-to-end bench: controller drives the device over the command pins
`timescale 1ns/100ps
`default_nettype none
module ddr2_bank_command_state_rules_test;
	import dbc_pkg::*;
	logic clock = 0;
	logic rst_b = 0;
	logic cmdValid = 0;
	dbc_cmd_t cmdKind = DBC_NOP;
	logic [1:0] cmdBank = 0;
	logic [13:0] cmdAddr = 0;
	logic cmdSent;
	logic [15:0] bankState;
	logic illegalCmd;
	logic burstInterrupt;
	dbc_cmd_t lastKind = DBC_NOP;
	int failCount = 0;
	int checked = 0;
	int nIll = 0;
	int nBurst = 0;
	localparam logic [3:0] PCODE [8] = '{4'hF, 4'h7, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
	dbc_if pins ();
	dbc_controller dbc_controller_i (.clock(clock), .rst_b(rst_b), .cmdPins(pins.ctrl), .cmdValid(cmdValid),
		.cmdKind(cmdKind), .cmdBank(cmdBank), .cmdAddr(cmdAddr), .cmdSent(cmdSent));
	dbc_device dbc_device_i (.clock(clock), .rst_b(rst_b), .cmdPins(pins.dev), .bankState(bankState),
		.illegalCmd(illegalCmd), .burstInterrupt(burstInterrupt));
	dbc_props #(.BANKS(4)) dbc_props_i (.clock(clock), .rst_b(rst_b), .csB(pins.csB), .rasB(pins.rasB),
		.casB(pins.casB), .weB(pins.weB), .ba(pins.ba), .bankState(bankState), .illegalCmd(illegalCmd));
	initial forever #2 clock = ~clock;
	task automatic chkVal(input string n, input logic [3:0] e, input logic [3:0] g);
		checked++;
		if (g !== e) begin
			failCount++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkCount(input string n, input int e, input int g);
		checked++;
		if (g != e) begin
			failCount++;
			$display("unexpected %s: expected %0d seen %0d", n, e, g);
		end
	endtask
	function automatic logic [3:0] st(input int b);
		return bankState[4*b +: 4];
	endfunction
	task automatic issue(input dbc_cmd_t k, input int b, input logic [13:0] a);
		cmdValid <= 1'b1;
		cmdKind <= k;
		cmdBank <= 2'(b);
		cmdAddr <= a;
		@(posedge clock);
	endtask
	task automatic idle(input int n);
		cmdValid <= 1'b0;
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic waitState(input int b, input dbc_bank_t s);
		int n;
		n = 0;
		while (st(b) !== s && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
		chkVal("state reached", s, st(b));
	endtask
	task automatic finalReport();
		$display("comparisons %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		if (cmdValid) lastKind <= cmdKind;
		if (illegalCmd === 1'b1) nIll++;
		if (burstInterrupt === 1'b1) nBurst++;
	end
	always @(negedge clock) begin
		if (cmdSent === 1'b1) chkVal("pins", PCODE[lastKind], {pins.csB, pins.rasB, pins.casB, pins.weB});
	end
	initial begin
		repeat (2000) @(posedge clock);
		failCount++;
		finalReport();
	end
	initial begin
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		idle(1);
		chkVal("idle pins", 4'hF, {pins.csB, pins.rasB, pins.casB, pins.weB});
		issue(DBC_ACT, 0, 14'h0000);
		issue(DBC_READ, 0, 14'h0000);
		issue(DBC_ACT, 1, 14'h0000);
		idle(8);
		chkVal("bank0", DBC_ACTIVE, st(0));
		chkVal("bank1", DBC_ACTIVE, st(1));
		chkCount("illegal", 1, nIll);
		issue(DBC_READ, 0, 14'h0000);
		idle(2);
		issue(DBC_READ, 0, 14'h0000);
		issue(DBC_WRIT, 0, 14'h0000);
		idle(10);
		chkCount("interrupt", 1, nBurst);
		chkCount("illegal", 2, nIll);
		issue(DBC_WRIT, 0, 14'h0400);
		issue(DBC_READ, 0, 14'h0000);
		idle(1);
		waitState(0, DBC_WREC_AP);
		issue(DBC_WRIT, 0, 14'h0000);
		idle(1);
		waitState(0, DBC_PRECHARGING);
		issue(DBC_PRE, 0, 14'h0000);
		issue(DBC_ACT, 0, 14'h0000);
		idle(8);
		chkVal("bank0", DBC_IDLE, st(0));
		chkCount("illegal", 5, nIll);
		issue(DBC_WRIT, 1, 14'h0000);
		idle(1);
		waitState(1, DBC_WREC);
		issue(DBC_WRIT, 1, 14'h0000);
		idle(2);
		chkVal("bank1", DBC_WRITING, st(1));
		idle(16);
		chkVal("bank1", DBC_ACTIVE, st(1));
		issue(DBC_PRE, 1, 14'h0400);
		idle(8);
		issue(DBC_AREF, 0, 14'h0000);
		issue(DBC_ACT, 2, 14'h0000);
		idle(20);
		chkVal("bank2", DBC_IDLE, st(2));
		issue(DBC_MRS, 0, 14'h0000);
		issue(DBC_PRE, 3, 14'h0000);
		issue(DBC_NOP, 3, 14'h0000);
		idle(6);
		chkCount("illegal", 7, nIll);
		chkVal("bank3", DBC_IDLE, st(3));
		finalReport();
	end
endmodule
`default_nettype wire

// >>> verilog/dbc_controller.sv
// controller end: registers a user command onto the command pins
`timescale 1ns/100ps
`default_nettype none
`include "dbc_consts.svh"
module dbc_controller #(
	parameter int BANKS = 4,
	parameter int AW = 14
) (
	input wire logic clock,
	input wire logic rst_b,
	dbc_if.ctrl cmdPins,
	input wire logic cmdValid,
	input wire dbc_pkg::dbc_cmd_t cmdKind,
	input wire logic [$clog2(BANKS)-1:0] cmdBank,
	input wire logic [AW-1:0] cmdAddr,
	output logic cmdSent
);
	import dbc_pkg::*;
	logic [3:0] pins_r;
	logic [3:0] pins_nxt;
	logic [$clog2(BANKS)-1:0] ba_r;
	logic [$clog2(BANKS)-1:0] ba_nxt;
	logic [AW-1:0] addr_r;
	logic [AW-1:0] addr_nxt;
	logic sent_r;
	logic sent_nxt;

	// legality toward bank state is the user's duty [RQ4] [RQ11] [RQ12] [RQ13]
	always_comb begin
		pins_nxt = 4'hF;
		ba_nxt = ba_r;
		addr_nxt = addr_r;
		sent_nxt = 1'b0;
		if (cmdValid) begin
			sent_nxt = 1'b1;
			ba_nxt = cmdBank;
			addr_nxt = cmdAddr;
			case (cmdKind) // [RQ2]
				DBC_DSL: pins_nxt = 4'hF;
				DBC_NOP: pins_nxt = 4'h7;
				DBC_READ: pins_nxt = 4'h5;
				DBC_WRIT: pins_nxt = 4'h4;
				DBC_ACT: pins_nxt = 4'h3;
				DBC_PRE: pins_nxt = 4'h2;
				DBC_AREF: pins_nxt = 4'h1;
				default: pins_nxt = 4'h0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pins_r <= 4'hF;
			ba_r <= '0;
			addr_r <= '0;
			sent_r <= 1'b0;
		end else begin
			pins_r <= pins_nxt;
			ba_r <= ba_nxt;
			addr_r <= addr_nxt;
			sent_r <= sent_nxt;
		end
	end

	assign cmdPins.csB = pins_r[3];
	assign cmdPins.rasB = pins_r[2];
	assign cmdPins.casB = pins_r[1];
	assign cmdPins.weB = pins_r[0];
	assign cmdPins.ba = ba_r;
	assign cmdPins.addr = addr_r;
	assign cmdSent = sent_r;
endmodule
`default_nettype wire

// >>> verilog/dbc_device.sv
// memory device end: per-bank command acceptance state machines
`timescale 1ns/100ps
`default_nettype none
`include "dbc_consts.svh"
module dbc_device #(
	parameter int BANKS = 4,
	parameter int AW = 14,
	parameter int BURST_LEN = `DBC_BL_LONG,
	parameter int TRP_CK = `DBC_CYC(`DBC_TRP_PS),
	parameter int TRCD_CK = `DBC_CYC(`DBC_TRCD_PS),
	parameter int TWR_CK = `DBC_CYC(`DBC_TWR_PS),
	parameter int TRC_CK = `DBC_CYC(`DBC_TRC_PS),
	parameter int TMRD_CK = `DBC_TMRD_CK
) (
	input wire logic clock,
	input wire logic rst_b,
	dbc_if.dev cmdPins,
	output logic [4*BANKS-1:0] bankState,
	output logic illegalCmd,
	output logic burstInterrupt
);
	import dbc_pkg::*;
	localparam int CW = 8;
	dbc_cmd_t cmd;
	logic a10;
	dbc_bank_t st_r [BANKS];
	dbc_bank_t st_nxt [BANKS];
	logic [CW-1:0] cnt_r [BANKS];
	logic [CW-1:0] cnt_nxt [BANKS];
	logic [BANKS-1:0] bad;
	logic [BANKS-1:0] intr;
	logic allIdle;
	logic devBusy;
	logic illegal_r;
	logic illegal_nxt;
	logic intr_r;
	logic intr_nxt;

	assign cmd = dbc_decode(cmdPins.csB, cmdPins.rasB, cmdPins.casB, cmdPins.weB); // [RQ2]
	assign a10 = cmdPins.addr[`DBC_A10_BIT];

	always_comb begin
		allIdle = 1'b1;
		devBusy = 1'b0;
		for (int i = 0; i < BANKS; i++) begin
			if (st_r[i] != DBC_IDLE) allIdle = 1'b0;
			if (st_r[i] == DBC_REFRESHING || st_r[i] == DBC_MODE_ACC) devBusy = 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : gBank
			logic sel;
			logic quiet;
			logic [CW-1:0] left;
			assign sel = (cmdPins.ba == $clog2(BANKS)'(g));
			assign quiet = (cmd == DBC_DSL || cmd == DBC_NOP);
			assign left = cnt_r[g] - 8'h01;
			always_comb begin
				st_nxt[g] = st_r[g];
				cnt_nxt[g] = (cnt_r[g] != 8'h00) ? left : 8'h00;
				bad[g] = 1'b0;
				intr[g] = 1'b0;
				case (st_r[g]) // [RQ1]
					DBC_IDLE: begin
						if (cmd == DBC_AREF || cmd == DBC_MRS) begin
							if (!allIdle) bad[g] = 1'b1; // [RQ11]
							else begin
								st_nxt[g] = (cmd == DBC_AREF) ? DBC_REFRESHING : DBC_MODE_ACC;
								cnt_nxt[g] = (cmd == DBC_AREF) ? CW'(TRC_CK) : CW'(TMRD_CK);
							end
						end else if (cmd == DBC_ACT && sel) begin
							st_nxt[g] = DBC_ACTIVATING;
							cnt_nxt[g] = CW'(TRCD_CK);
						end else if (cmd == DBC_PRE && (sel || a10)) begin
							st_nxt[g] = DBC_PRECHARGING;
							cnt_nxt[g] = CW'(TRP_CK);
						end else if ((cmd == DBC_READ || cmd == DBC_WRIT) && sel) bad[g] = 1'b1;
					end
					DBC_ACTIVATING: begin
						if (!quiet && (sel || cmd == DBC_AREF || cmd == DBC_MRS)) bad[g] = 1'b1; // [RQ6] [RQ4]
						else if (cnt_r[g] <= 8'h01) st_nxt[g] = DBC_ACTIVE; // [RQ6]
					end
					DBC_ACTIVE, DBC_READING, DBC_WRITING: begin
						if (cmd == DBC_AREF || cmd == DBC_MRS) bad[g] = 1'b1;
						else if (cmd == DBC_PRE && (sel || a10)) begin
							if (st_r[g] == DBC_ACTIVE) begin
								st_nxt[g] = DBC_PRECHARGING;
								cnt_nxt[g] = CW'(TRP_CK);
							end else bad[g] = 1'b1;
						end else if ((cmd == DBC_READ || cmd == DBC_WRIT) && sel) begin
							if (st_r[g] != DBC_ACTIVE) begin
								intr[g] = 1'b1;
								// [RQ12] [RQ13]
								if (BURST_LEN != `DBC_BL_LONG || cnt_r[g] != CW'(`DBC_BOUNDARY / 2)
									|| (cmd == DBC_READ) != (st_r[g] == DBC_READING)) bad[g] = 1'b1;
							end
							if (!bad[g]) begin
								if (cmd == DBC_READ) st_nxt[g] = a10 ? DBC_READ_AP : DBC_READING;
								else st_nxt[g] = a10 ? DBC_WRITE_AP : DBC_WRITING;
								cnt_nxt[g] = CW'(BURST_LEN / 2);
							end
						end else if (cmd == DBC_ACT && sel) bad[g] = 1'b1;
						else if (cnt_r[g] <= 8'h01 && st_r[g] == DBC_READING) st_nxt[g] = DBC_ACTIVE;
						else if (cnt_r[g] <= 8'h01 && st_r[g] == DBC_WRITING) begin
							st_nxt[g] = DBC_WREC;
							cnt_nxt[g] = CW'(TWR_CK);
						end
					end
					DBC_READ_AP, DBC_WRITE_AP: begin
						if (!quiet && (sel || cmd == DBC_AREF || cmd == DBC_MRS || (cmd == DBC_PRE && a10)))
							bad[g] = 1'b1; // [RQ3]
						else if (cnt_r[g] <= 8'h01) begin // [RQ3]
							st_nxt[g] = (st_r[g] == DBC_READ_AP) ? DBC_PRECHARGING : DBC_WREC_AP;
							cnt_nxt[g] = (st_r[g] == DBC_READ_AP) ? CW'(TRP_CK) : CW'(TWR_CK);
						end
					end
					DBC_PRECHARGING: begin
						if (cmd == DBC_PRE && (sel || a10)) st_nxt[g] = st_r[g]; // [RQ5]
						else if (!quiet && (sel || cmd == DBC_AREF || cmd == DBC_MRS)) bad[g] = 1'b1; // [RQ5]
						if (cnt_r[g] <= 8'h01) st_nxt[g] = DBC_IDLE; // [RQ5]
					end
					DBC_WREC: begin
						if (cmd == DBC_WRIT && sel) begin // [RQ7]
							st_nxt[g] = a10 ? DBC_WRITE_AP : DBC_WRITING;
							cnt_nxt[g] = CW'(BURST_LEN / 2);
						end else if (!quiet && (sel || cmd == DBC_AREF || cmd == DBC_MRS || (cmd == DBC_PRE && a10)))
							bad[g] = 1'b1; // [RQ7]
						else if (cnt_r[g] <= 8'h01) st_nxt[g] = DBC_ACTIVE; // [RQ7]
					end
					DBC_WREC_AP: begin
						if (!quiet && (sel || cmd == DBC_AREF || cmd == DBC_MRS || (cmd == DBC_PRE && a10)))
							bad[g] = 1'b1; // [RQ8]
						else if (cnt_r[g] <= 8'h01) begin // [RQ8]
							st_nxt[g] = DBC_PRECHARGING;
							cnt_nxt[g] = CW'(TRP_CK);
						end
					end
					DBC_REFRESHING, DBC_MODE_ACC: begin
						if (!quiet) bad[g] = 1'b1; // [RQ9] [RQ10]
						if (cnt_r[g] <= 8'h01) st_nxt[g] = DBC_IDLE; // [RQ9] [RQ10]
					end
					default: st_nxt[g] = DBC_IDLE;
				endcase
			end
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					st_r[g] <= DBC_IDLE;
					cnt_r[g] <= 8'h00;
				end else begin
					st_r[g] <= st_nxt[g];
					cnt_r[g] <= cnt_nxt[g];
				end
			end
			assign bankState[4*g +: 4] = st_r[g];
		end
	endgenerate

	always_comb begin
		illegal_nxt = (|bad) || (devBusy && cmd != DBC_DSL && cmd != DBC_NOP);
		intr_nxt = (|intr) && !(|bad);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			illegal_r <= 1'b0;
			intr_r <= 1'b0;
		end else begin
			illegal_r <= illegal_nxt;
			intr_r <= intr_nxt;
		end
	end

	assign illegalCmd = illegal_r;
	assign burstInterrupt = intr_r;
endmodule
`default_nettype wire
